/* design/rsq_top.sv */
/*
 Reset and interrupt sequencer: reset timing, reset cause register,
 watchdog clearing, interrupt entry control, AHB-Lite register slave.
 Assumes ref_tick is a one-cycle enable at the crystal reference rate and
 that the reset pin input is asynchronous.
*/
// Functional notes
// - Reset aborts instruction, loads reset vector
// - After reset bus clock is reference/4
// - Low reset pin is external reset
// - Internal reset: pin 32, CPU 32 more
// - Power-on: 4096 gated, then 32, 64
// - Power-on sets own flag, clears others
// - Watchdog overflow resets, sets watchdog flag
// - Any watchdog location write clears counter
// - Low supply: hold, 4096, then 32/64
// - Illegal opcode or disabled stop resets
// - Unmapped fetch resets; data read does not
// - Cause register read-only, read clears
// - Sample pin 32 after release
// - Cause flags accumulate until read
// - Interrupt waits for instruction end
// - Entry stacks, masks, loads vector; return restores
// - Latched interrupt cannot be pre-empted
// - Highest pending serviced at each boundary
// - Index high byte not stacked
// - Software trap ignores global mask
// - Trap stacks PC, hardware PC minus one
// - Priority zero is highest
// - Global mask blocks all but trap
`timescale 1ns/1ps
`default_nettype none
module rsq_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ref_tick,
	input  wire logic        por_pulse,
	input  wire logic        low_supply,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	input  wire logic        fetch_valid,
	input  wire logic [15:0] fetch_addr,
	input  wire logic [7:0]  fetch_opcode,
	input  wire logic        opcode_legal,
	input  wire logic        addr_mapped,
	input  wire logic        cpu_wr,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        insn_done,
	input  wire logic        ccr_imask,
	input  wire logic        trap_insn,
	input  wire logic        rti_done,
	input  wire logic [15:0] cpu_pc,
	input  wire logic [15:0] irq_pend,
	output logic             cpu_reset,
	output logic             clk_gate_n,
	output logic [1:0]       bus_div,
	output logic             pc_load,
	output logic [15:0]      pc_vector,
	output logic             stack_push,
	output logic [15:0]      stack_pc,
	output logic             stack_index_hi,
	output logic             set_imask,
	output logic             restore_regs
);
	rsq_irq_if irq ();
	rsq_irq_arb u_arb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.irq     (irq)
	);

	function automatic logic [7:0] flag(input int pos);
		flag = 8'(1 << pos);
	endfunction : flag

	// Pin synchroniser
	logic pin_s1_ff;
	logic pin_s2_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end
		else
		begin
			pin_s1_ff <= rst_pin_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Bus slave
	logic       aph_ff;
	logic       nxt_aph;
	logic       wr_ff;
	logic       nxt_wr;
	logic [7:0] adr_ff;
	logic [7:0] nxt_adr;
	logic       rd_cause;
	logic       wr_ctrl;
	logic       wr_wdog;
	always_comb
	begin
		nxt_aph = hsel && hready && htrans[1];
		nxt_wr  = hwrite;
		nxt_adr = haddr;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph_ff <= 1'b0;
			wr_ff  <= 1'b0;
			adr_ff <= 8'h00;
		end
		else
		begin
			aph_ff <= nxt_aph;
			wr_ff  <= nxt_wr;
			adr_ff <= nxt_adr;
		end
	end
	assign rd_cause  = aph_ff && !wr_ff && adr_ff == rsq_pkg::ADDR_CAUSE;
	assign wr_ctrl   = aph_ff && wr_ff && adr_ff == rsq_pkg::ADDR_CTRL;
	assign wr_wdog   = aph_ff && wr_ff && adr_ff == rsq_pkg::ADDR_WDOG;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Control register
	logic [1:0] ctrl_ff;
	logic [1:0] nxt_ctrl;
	always_comb
	begin
		nxt_ctrl = wr_ctrl ? hwdata[1:0] : ctrl_ff;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_ff <= rsq_pkg::CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	// Watchdog counter
	logic [15:0] wdog_ff;
	logic [15:0] nxt_wdog;
	logic        wdog_ovf;
	logic        cpu_wdog_wr;
	logic        in_reset;
	assign cpu_wdog_wr = cpu_wr && cpu_addr == rsq_pkg::WDOG_LOC;
	assign wdog_ovf    = ctrl_ff[rsq_pkg::CTL_WDOG_EN] && !in_reset && ref_tick
		&& wdog_ff == rsq_pkg::WDOG_TOP;
	always_comb
	begin
		nxt_wdog = wdog_ff;
		if (cpu_wdog_wr || wr_wdog || in_reset)
			nxt_wdog = 16'h0000;
		else if (ctrl_ff[rsq_pkg::CTL_WDOG_EN] && ref_tick)
			nxt_wdog = wdog_ff + 16'h0001;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wdog_ff <= 16'h0000;
		else
			wdog_ff <= nxt_wdog;
	end

	// Fault detection
	logic bad_op;
	logic bad_adr;
	assign bad_op  = fetch_valid && !in_reset && (!opcode_legal
		|| (fetch_opcode == rsq_pkg::OPC_STOP && !ctrl_ff[rsq_pkg::CTL_STOP_EN]));
	assign bad_adr = fetch_valid && !in_reset && !addr_mapped;

	// Reset sequencer
	rsq_pkg::rsq_state_t         st_ff;
	rsq_pkg::rsq_state_t         nxt_st;
	logic [rsq_pkg::CNT_W-1:0]   cnt_ff;
	logic [rsq_pkg::CNT_W-1:0]   nxt_cnt;
	logic                        smp_ff;
	logic                        nxt_smp;
	logic [5:0]                  scnt_ff;
	logic [5:0]                  nxt_scnt;
	logic [7:0]                  cause_ff;
	logic [7:0]                  nxt_cause;
	logic                        int_rst;
	logic                        ext_rst;
	logic                        smp_low;
	logic [7:0]                  set_bits;
	assign int_rst = wdog_ovf || bad_op || bad_adr;
	assign ext_rst = !pin_s2_ff && st_ff == rsq_pkg::RSQ_RUN;
	assign smp_low = smp_ff && ref_tick && scnt_ff == 6'(rsq_pkg::SAMPLE_CYC - 1)
		&& !pin_s2_ff;
	always_comb
	begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_smp  = smp_ff;
		nxt_scnt = scnt_ff;
		set_bits = 8'h00;
		if (smp_ff && ref_tick)
		begin
			nxt_scnt = scnt_ff + 6'h01;
			if (scnt_ff == 6'(rsq_pkg::SAMPLE_CYC - 1))
				nxt_smp = 1'b0;
		end
		if (smp_low)
			set_bits = set_bits | flag(rsq_pkg::FLG_PIN);
		if (low_supply)
		begin
			nxt_st   = rsq_pkg::RSQ_LOWV;
			nxt_cnt  = '0;
			set_bits = set_bits | flag(rsq_pkg::FLG_LOWV);
		end
		else unique case (st_ff)
			rsq_pkg::RSQ_RUN:
			begin
				nxt_cnt = '0;
				if (int_rst)
				begin
					nxt_st = rsq_pkg::RSQ_PIN;
					if (wdog_ovf)
						set_bits = set_bits | flag(rsq_pkg::FLG_WDOG);
					if (bad_op)
						set_bits = set_bits | flag(rsq_pkg::FLG_BADOP);
					if (bad_adr)
						set_bits = set_bits | flag(rsq_pkg::FLG_BADADR);
				end
				else if (ext_rst)
				begin
					nxt_st   = rsq_pkg::RSQ_EXT;
					set_bits = set_bits | flag(rsq_pkg::FLG_PIN);
				end
			end
			rsq_pkg::RSQ_EXT:
				if (pin_s2_ff)
					nxt_st = rsq_pkg::RSQ_RUN;
			// First tick after supply recovery counts into the delay
			rsq_pkg::RSQ_LOWV, rsq_pkg::RSQ_OSC:
			begin
				nxt_st = rsq_pkg::RSQ_OSC;
				if (ref_tick)
				begin
					nxt_cnt = cnt_ff + 1'b1;
					if (cnt_ff == rsq_pkg::CNT_W'(rsq_pkg::OSC_CYC - 1))
					begin
						nxt_st  = rsq_pkg::RSQ_PIN;
						nxt_cnt = '0;
					end
				end
			end
			rsq_pkg::RSQ_PIN:
				if (ref_tick)
				begin
					nxt_cnt = cnt_ff + 1'b1;
					if (cnt_ff == rsq_pkg::CNT_W'(rsq_pkg::PIN_CYC - 1))
					begin
						nxt_st   = rsq_pkg::RSQ_HOLD;
						nxt_cnt  = '0;
						nxt_smp  = 1'b1;
						nxt_scnt = 6'h00;
					end
				end
			rsq_pkg::RSQ_HOLD:
				if (ref_tick)
				begin
					nxt_cnt = cnt_ff + 1'b1;
					if (cnt_ff == rsq_pkg::CNT_W'(rsq_pkg::CPU_CYC - 1))
						nxt_st = rsq_pkg::RSQ_RUN;
				end
			default:
				nxt_st = rsq_pkg::RSQ_RUN;
		endcase
		// Set wins over read clear; flags accumulate
		nxt_cause = (rd_cause ? 8'h00 : cause_ff) | set_bits;
		if (por_pulse)
		begin
			nxt_st    = rsq_pkg::RSQ_OSC;
			nxt_cnt   = '0;
			nxt_cause = rsq_pkg::CAUSE_RESET;
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff    <= rsq_pkg::RSQ_OSC;
			cnt_ff   <= '0;
			smp_ff   <= 1'b0;
			scnt_ff  <= 6'h00;
			cause_ff <= rsq_pkg::CAUSE_RESET;
		end
		else
		begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			smp_ff   <= nxt_smp;
			scnt_ff  <= nxt_scnt;
			cause_ff <= nxt_cause;
		end
	end
	assign in_reset    = st_ff != rsq_pkg::RSQ_RUN;
	assign cpu_reset   = in_reset;
	assign rst_pin_oe  = st_ff == rsq_pkg::RSQ_OSC || st_ff == rsq_pkg::RSQ_PIN
		|| st_ff == rsq_pkg::RSQ_LOWV;
	assign rst_pin_out = 1'b0;
	assign clk_gate_n  = !(st_ff == rsq_pkg::RSQ_OSC || st_ff == rsq_pkg::RSQ_LOWV);

	// Bus divider and vector loading
	logic [1:0] div_ff;
	logic [1:0] nxt_div;
	logic       run_q_ff;
	always_comb
	begin
		nxt_div = div_ff;
		if (in_reset)
			nxt_div = rsq_pkg::BUS_DIV_RESET;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_ff   <= rsq_pkg::BUS_DIV_RESET;
			run_q_ff <= 1'b0;
		end
		else
		begin
			div_ff   <= nxt_div;
			run_q_ff <= !in_reset;
		end
	end
	assign bus_div = div_ff;

	// Interrupt entry
	assign irq.pend      = irq_pend;
	assign irq.imask     = ccr_imask;
	assign irq.insn_done = insn_done || rti_done;
	assign irq.trap      = trap_insn;
	logic        push_ff;
	logic        nxt_push;
	logic [15:0] spc_ff;
	logic [15:0] nxt_spc;
	logic [15:0] vec_ff;
	logic [15:0] nxt_vec;
	logic        rst_vec;
	assign rst_vec = !in_reset && !run_q_ff;
	always_comb
	begin
		nxt_push = irq.take;
		nxt_spc  = spc_ff;
		nxt_vec  = vec_ff;
		if (irq.take)
		begin
			nxt_spc = trap_insn ? cpu_pc : cpu_pc - 16'h0001;
			nxt_vec = trap_insn ? rsq_pkg::TRAP_VECTOR :
				rsq_pkg::TOP_VECTOR - {10'h000, 5'(irq_sel_c()), 1'b0};
		end
		if (rst_vec)
			nxt_vec = rsq_pkg::RESET_VECTOR;
	end
	function automatic logic [4:0] irq_sel_c();
		logic [15:0] p;
		p = irq_pend;
		irq_sel_c = 5'h00;
		for (int i = rsq_pkg::NSRC - 1; i >= 0; i--)
			if (p[i])
				irq_sel_c = 5'(i);
	endfunction : irq_sel_c
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			push_ff <= 1'b0;
			spc_ff  <= 16'h0000;
			vec_ff  <= rsq_pkg::RESET_VECTOR;
		end
		else
		begin
			push_ff <= nxt_push;
			spc_ff  <= nxt_spc;
			vec_ff  <= nxt_vec;
		end
	end
	logic pcl_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pcl_ff <= 1'b0;
		else
			pcl_ff <= irq.take || rst_vec;
	end
	assign pc_load        = pcl_ff;
	assign pc_vector      = vec_ff;
	assign stack_push     = push_ff;
	assign stack_pc       = spc_ff;
	assign stack_index_hi = 1'b0;
	assign set_imask      = push_ff;
	assign restore_regs   = rti_done;

	// Read data
	logic [31:0] rdat_c;
	always_comb
	begin
		unique case (adr_ff)
			rsq_pkg::ADDR_CAUSE:    rdat_c = {24'h000000, cause_ff};
			rsq_pkg::ADDR_CTRL:     rdat_c = {30'h00000000, ctrl_ff};
			rsq_pkg::ADDR_WDOG:     rdat_c = {16'h0000, wdog_ff};
			rsq_pkg::ADDR_IRQ_PEND: rdat_c = {16'h0000, irq_pend};
			rsq_pkg::ADDR_IRQ_STAT: rdat_c = {26'h0000000, irq.busy, irq.sel};
			default:                rdat_c = 32'h00000000;
		endcase
	end
	assign hrdata = (aph_ff && !wr_ff) ? rdat_c : 32'h00000000;

	AST_PIN_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_ff == rsq_pkg::RSQ_RUN && int_rst && !low_supply && !por_pulse)
		|=> rst_pin_oe) else $error("Pin not driven on internal reset");
	AST_CAUSE_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_cause && set_bits == 8'h00 && !por_pulse) |=> cause_ff == 8'h00)
		else $error("Cause not cleared by read");
	AST_POR_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
		por_pulse |=> cause_ff == rsq_pkg::CAUSE_RESET) else $error("Power-on flag wrong");
	AST_ACCUM: assert property (@(posedge hclk) disable iff (!hresetn)
		(!rd_cause && !por_pulse) |=> (cause_ff & $past(cause_ff)) == $past(cause_ff))
		else $error("Cause flag lost");
	AST_WDOG_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_wdog_wr |=> wdog_ff == 16'h0000) else $error("Watchdog not cleared");
	AST_DIV: assert property (@(posedge hclk) disable iff (!hresetn)
		in_reset |=> bus_div == rsq_pkg::BUS_DIV_RESET) else $error("Bus divider wrong");
	AST_TRAP_PC: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq.take && trap_insn) |=> stack_pc == $past(cpu_pc)) else $error("Trap PC wrong");
	AST_HW_PC: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq.take && !trap_insn) |=> stack_pc == $past(cpu_pc) - 16'h0001)
		else $error("Hardware PC wrong");
	AST_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
		!clk_gate_n |-> rst_pin_oe) else $error("Clocks gated without pin");
endmodule : rsq_top
`default_nettype wire

/* design/rsq_pkg.sv */
/*
 Package for the reset and interrupt sequencer: register map, flag
 positions, timing counts and state types.
 Assumes a 200 MHz hclk; the crystal reference arrives as a one-cycle enable.
*/
package rsq_pkg;
	localparam logic [7:0]  ADDR_CAUSE     = 8'h00;
	localparam logic [7:0]  ADDR_CTRL      = 8'h04;
	localparam logic [7:0]  ADDR_WDOG      = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_PEND  = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
	localparam int          FLG_POR        = 7;
	localparam int          FLG_PIN        = 6;
	localparam int          FLG_WDOG       = 5;
	localparam int          FLG_BADOP      = 4;
	localparam int          FLG_BADADR     = 3;
	localparam int          FLG_LOWV       = 1;
	localparam logic [7:0]  CAUSE_RESET    = 8'h80;
	localparam int          CTL_STOP_EN    = 0;
	localparam int          CTL_WDOG_EN    = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h2;
	localparam logic [15:0] RESET_VECTOR   = 16'hfffe;
	localparam logic [15:0] TRAP_VECTOR    = 16'hfffc;
	localparam logic [15:0] TOP_VECTOR     = 16'hfffa;
	localparam logic [15:0] WDOG_LOC       = 16'hffff;
	localparam logic [1:0]  BUS_DIV_RESET  = 2'h3;
	localparam int          PIN_CYC        = 32;
	localparam int          CPU_CYC        = 32;
	localparam int          SAMPLE_CYC     = 32;
	localparam int          OSC_CYC        = 4096;
	localparam int          CNT_W          = 13;
	localparam int          NSRC           = 16;
	localparam logic [15:0] WDOG_TOP       = 16'hffff;
	localparam logic [7:0]  OPC_STOP       = 8'h8e;
	typedef enum logic [2:0] {
		RSQ_RUN, RSQ_OSC, RSQ_LOWV, RSQ_PIN, RSQ_HOLD, RSQ_EXT
	} rsq_state_t;
	typedef enum logic [1:0] {
		RSQ_IDLE, RSQ_WAIT, RSQ_STACK
	} rsq_irq_state_t;
endpackage : rsq_pkg

/* design/rsq_irq_if.sv */
/*
 Interface carrying interrupt entry signals between sequencer and arbiter.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface rsq_irq_if;
	logic [15:0] pend;
	logic        imask;
	logic        insn_done;
	logic        trap;
	logic        take;
	logic [4:0]  sel;
	logic        busy;
	modport arb (input pend, imask, insn_done, trap, output take, sel, busy);
	modport top (output pend, imask, insn_done, trap, input take, sel, busy);
endinterface : rsq_irq_if
`default_nettype wire

/* design/rsq_irq_arb.sv */
/*
 Interrupt arbiter: priority pick at instruction boundaries and latching.
 Assumes the CPU raises insn_done for one cycle at each instruction end.
*/
`timescale 1ns/1ps
`default_nettype none
module rsq_irq_arb (
	input  wire logic hclk,
	input  wire logic hresetn,
	rsq_irq_if.arb    irq
);
	function automatic logic [4:0] pick(input logic [15:0] p);
		pick = 5'h10;
		for (int i = rsq_pkg::NSRC - 1; i >= 0; i--)
			if (p[i])
				pick = 5'(i);
	endfunction : pick

	logic        busy_ff;
	logic        nxt_busy;
	logic [4:0]  sel_ff;
	logic [4:0]  nxt_sel;
	logic        take_c;
	logic [4:0]  cand;

	always_comb
	begin
		cand     = pick(irq.pend);
		take_c   = 1'b0;
		nxt_busy = busy_ff;
		nxt_sel  = sel_ff;
		if (!busy_ff && irq.insn_done)
		begin
			if (irq.trap)
			begin
				take_c   = 1'b1;
				nxt_sel  = 5'h1f;
				nxt_busy = 1'b1;
			end
			else if (!irq.imask && cand != 5'h10)
			begin
				take_c   = 1'b1;
				nxt_sel  = cand;
				nxt_busy = 1'b1;
			end
		end
		else if (busy_ff && irq.imask)
			nxt_busy = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy_ff <= 1'b0;
			sel_ff  <= 5'h00;
		end
		else
		begin
			busy_ff <= nxt_busy;
			sel_ff  <= nxt_sel;
		end
	end

	assign irq.take = take_c;
	assign irq.sel  = sel_ff;
	assign irq.busy = busy_ff;

	AST_NO_PREEMPT: assert property (@(posedge hclk) disable iff (!hresetn)
		busy_ff |-> !take_c) else $error("Second interrupt latched while busy");
	AST_MASK_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq.imask && !irq.trap) |-> !take_c) else $error("Masked interrupt taken");
	AST_BOUNDARY: assert property (@(posedge hclk) disable iff (!hresetn)
		take_c |-> irq.insn_done) else $error("Interrupt taken mid instruction");
endmodule : rsq_irq_arb
`default_nettype wire

/* verif/rsq_ext_model.sv */
/*
 Far side model: crystal reference tick and the shared reset line.
 Assumes one hclk domain; ext_hold stands for an outside device.
*/
`timescale 1ns/1ps
`default_nettype none
module rsq_ext_model #(
	parameter int DIV = 1
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ext_hold,
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	output logic      rst_pin_in,
	output logic      ref_tick
);
	int cnt_ff;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cnt_ff <= 0;
		else
			cnt_ff <= (cnt_ff + 1) % DIV;
	assign ref_tick = (cnt_ff == DIV - 1);
	// Pulled-up line, low while any party pulls
	assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_hold);
endmodule : rsq_ext_model
`default_nettype wire

/* verif/test_reset_and_interrupt_sequencer.sv */
/*
 Testbench for the sequencer: reset timing, cause flags, watchdog,
 interrupt entry. Assumes the reference tick runs at the hclk rate.
*/
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_interrupt_sequencer;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_hold;
	logic [7:0]  haddr, fetch_opcode;
	logic [1:0]  htrans, bus_div;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        ref_tick, por_pulse, low_supply, rst_pin_in, rst_pin_out, rst_pin_oe;
	logic        fetch_valid, opcode_legal, addr_mapped, cpu_wr, insn_done, ccr_imask;
	logic        trap_insn, rti_done, cpu_reset, clk_gate_n, pc_load, stack_push;
	logic        stack_index_hi, set_imask, restore_regs;
	logic [15:0] fetch_addr, cpu_addr, cpu_pc, irq_pend, pc_vector, stack_pc;
	int          errors, tests_run, p, c;

	rsq_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ref_tick, .por_pulse,
		.low_supply, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .fetch_valid, .fetch_addr,
		.fetch_opcode, .opcode_legal, .addr_mapped, .cpu_wr, .cpu_addr, .insn_done,
		.ccr_imask, .trap_insn, .rti_done, .cpu_pc, .irq_pend, .cpu_reset, .clk_gate_n,
		.bus_div, .pc_load, .pc_vector, .stack_push, .stack_pc, .stack_index_hi,
		.set_imask, .restore_regs);
	rsq_ext_model #(.DIV(1)) ext_u (.hclk, .hresetn, .ext_hold, .rst_pin_out,
		.rst_pin_oe, .rst_pin_in, .ref_tick);

	initial
	begin
		hclk = 0;
		forever #2.5 hclk = ~hclk;
	end

	task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task cause(input logic [31:0] exp);
		ahb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		cmp("cause", exp, rd);
	endtask : cause

	task kick;
		@(posedge hclk);
		cpu_wr <= 1'b1;
		cpu_addr <= rsq_pkg::WDOG_LOC;
		@(posedge hclk);
		cpu_wr <= 1'b0;
	endtask : kick

	// Ticks with pin driven, then ticks with only the CPU held
	task seq_len(input int lim);
		p = 0;
		c = 0;
		for (int n = 0; n < lim; n++)
		begin
			@(negedge hclk);
			if (ref_tick && rst_pin_oe) p++;
			else if (ref_tick && cpu_reset) c++;
			if (p > 0 && cpu_reset === 1'b0) break;
		end
	endtask : seq_len

	task fetch(input logic [7:0] op, input logic mapped);
		@(posedge hclk);
		fetch_valid <= 1'b1;
		fetch_opcode <= op;
		addr_mapped <= mapped;
		@(posedge hclk);
		fetch_valid <= 1'b0;
		addr_mapped <= 1'b1;
		seq_len(400);
		cmp("pin ticks", 32, p);
		cmp("cpu ticks", 32, c);
		@(negedge hclk);
		cmp("vector", rsq_pkg::RESET_VECTOR, pc_vector);
		cmp("pc load", 1, pc_load);
	endtask : fetch

	task t_power_on;
		seq_len(9000);
		cmp("pin ticks", 4128, p);
		cmp("cpu ticks", 32, c);
		cmp("clk_gate_n", 1, clk_gate_n);
		cmp("bus_div", 3, bus_div);
		cause(32'h80);
		cause(32'h0);
		ahb(1'b1, rsq_pkg::ADDR_CAUSE, 32'hff);
		cause(32'h0);
		ahb(1'b0, 8'h20, 32'h0);
		cmp("unmapped", 0, rd);
		kick;
		ahb(1'b0, rsq_pkg::ADDR_WDOG, 32'h0);
		cmp("wdog count", 0, rd[31:4]);
	endtask : t_power_on

	task t_irq;
		@(posedge hclk);
		irq_pend <= 16'h0006;
		cpu_pc <= 16'h1234;
		@(posedge hclk);
		insn_done <= 1'b1;
		#1 cmp("push early", 0, stack_push);
		@(posedge hclk);
		irq_pend <= 16'h0001;
		#1 cmp("push", 1, stack_push);
		cmp("vector", 16'hfff8, pc_vector);
		cmp("stack pc", 16'h1233, stack_pc);
		cmp("set mask", 1, set_imask);
		cmp("index hi", 0, stack_index_hi);
		@(posedge hclk);
		insn_done <= 1'b0;
		ccr_imask <= 1'b1;
		#1 cmp("preempt", 0, stack_push);
		@(posedge hclk);
		insn_done <= 1'b1;
		@(posedge hclk);
		trap_insn <= 1'b1;
		cpu_pc <= 16'h2000;
		#1 cmp("masked", 0, stack_push);
		@(posedge hclk);
		trap_insn <= 1'b0;
		insn_done <= 1'b0;
		#1 cmp("trap push", 1, stack_push);
		cmp("trap vector", rsq_pkg::TRAP_VECTOR, pc_vector);
		cmp("trap pc", 16'h2000, stack_pc);
		@(posedge hclk);
		@(posedge hclk);
		ccr_imask <= 1'b0;
		rti_done <= 1'b1;
		irq_pend <= 16'h0008;
		#1 cmp("restore", 1, restore_regs);
		@(posedge hclk);
		rti_done <= 1'b0;
		irq_pend <= 16'h0;
		#1 cmp("rti push", 1, stack_push);
		cmp("rti vector", 16'hfff4, pc_vector);
	endtask : t_irq

	task t_faults;
		kick;
		addr_mapped <= 1'b0;
		repeat (40) @(posedge hclk);
		cmp("data read", 0, rst_pin_oe);
		addr_mapped <= 1'b1;
		ahb(1'b1, rsq_pkg::ADDR_CTRL, 32'h3);
		ahb(1'b0, rsq_pkg::ADDR_CTRL, 32'h0);
		cmp("ctrl", 3, rd);
		@(posedge hclk);
		fetch_valid <= 1'b1;
		fetch_opcode <= rsq_pkg::OPC_STOP;
		@(posedge hclk);
		fetch_valid <= 1'b0;
		repeat (4) @(posedge hclk);
		cmp("stop allowed", 0, rst_pin_oe);
		ahb(1'b1, rsq_pkg::ADDR_CTRL, 32'h2);
		fetch(rsq_pkg::OPC_STOP, 1'b1);
		fetch(8'h9d, 1'b0);
		cause(32'h18);
		@(posedge hclk);
		ext_hold <= 1'b1;
		repeat (20) @(posedge hclk);
		cmp("ext reset", 1, cpu_reset);
		ext_hold <= 1'b0;
		for (int n = 0; n < 500 && cpu_reset !== 1'b0; n++) @(negedge hclk);
		cause(32'h40);
		kick;
		low_supply <= 1'b1;
		repeat (50) @(posedge hclk);
		cmp("low pin", 1, rst_pin_oe);
		low_supply <= 1'b0;
		seq_len(9000);
		cmp("low pin ticks", 4128, p);
		cmp("low cpu ticks", 32, c);
		cause(32'h02);
		seq_len(70000);
		cmp("wdog pin ticks", 32, p);
		cmp("wdog cpu ticks", 32, c);
		cause(32'h20);
	endtask : t_faults

	// Pin flag set first, then a power-on pulse must leave only its own flag
	task t_por;
		@(posedge hclk);
		ext_hold <= 1'b1;
		repeat (5) @(posedge hclk);
		ext_hold <= 1'b0;
		por_pulse <= 1'b1;
		@(posedge hclk);
		por_pulse <= 1'b0;
		seq_len(9000);
		cmp("por pin ticks", 4128, p);
		cmp("por cpu ticks", 32, c);
		cause(32'h80);
	endtask : t_por

	task wrap_up;
		$display("Checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial
	begin
		{hresetn, hsel, hwrite, ext_hold, por_pulse, low_supply, fetch_valid} = '0;
		{cpu_wr, insn_done, ccr_imask, trap_insn, rti_done} = '0;
		{haddr, fetch_opcode, htrans, hwdata, fetch_addr, cpu_addr, cpu_pc, irq_pend} = '0;
		hsize = 3'h2;
		opcode_legal = 1'b1;
		addr_mapped = 1'b1;
		errors = 0;
		tests_run = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_power_on;
		t_irq;
		t_faults;
		t_por;
		wrap_up;
	end

	initial
	begin
		repeat (95000) @(posedge hclk);
		errors++;
		wrap_up;
	end
endmodule : test_reset_and_interrupt_sequencer
`default_nettype wire
